// *** design/psm_pkg.sv ***
// psm_pkg: constants, register map and carrier types for the program
// space data access mapper. assumes a 32-bit AXI4-Lite register bus.
package psm_pkg;
  localparam int PW = 24;
  localparam int DW = 16;
  // register byte addresses on the bus
  localparam logic [7:0] OFF_TBLPAGE  = 8'h00;
  localparam logic [7:0] OFF_VISPAGE  = 8'h04;
  localparam logic [7:0] OFF_CORECTL  = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  // field positions
  localparam int CFG_SPACE_BIT = 7;
  localparam int WIN_EN_BIT    = 2;
  // reset values
  localparam logic [7:0] RST_TBLPAGE = 8'h00;
  localparam logic [7:0] RST_VISPAGE = 8'h00;
  localparam logic [7:0] RST_CORECTL = 8'h00;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  localparam logic [PW-1:0] PC_STEP = 24'h000002;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_RDLO  = 3'h1,
    OP_RDHI  = 3'h2,
    OP_WRLO  = 3'h3,
    OP_WRHI  = 3'h4,
    OP_DATA  = 3'h5
  } psm_op_t;

  typedef struct packed {
    psm_op_t         op;
    logic            byteMode;
    logic [DW-1:0]   effAddr;
    logic [DW-1:0]   wrData;
  } psm_req_t;

  typedef struct packed {
    logic            valid;
    logic            cfgSpace;
    logic            wr;
    logic [PW-1:0]   addr;
    logic [PW-1:0]   wrData;
    logic [2:0]      laneEn;
  } psm_mem_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM  = 2'b01,
    ST_EXTRA = 2'b11
  } psm_state_t;
endpackage

// *** design/psm_mapper.sv ***
// psm_mapper: turns cpu data-space requests into program memory accesses.
// assumes program memory shows read data while memReq stands.
// Summary of operation
// - 24-bit program words reached from 16-bit data
// - table address is page above effective address
// - page top bit selects configuration memory
// - window address: page above low 15 bits
// - window used when address msb and enable
// - address bit 15 comes from page bit 0
// - fetch address: zero, pc bits, zero
// - program counter steps by two per word
// - low read word returns bits 15..0
// - low read byte picks byte by select
// - high read word gives phantom zero byte
// - high read byte: upper byte or zero
// - low/high writes of byte or word
// - upper data half maps to any user memory page
// - window read returns low 16 bits only
// - window read costs one extra cycle
// - window suspended during table operations
`timescale 1ns/1ps
`default_nettype none
module psm_mapper
  import psm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite slave
  input  wire logic [7:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [7:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // cpu side
  input  wire psm_pkg::psm_req_t cpuReq,
  input  wire logic              pcLoad,
  input  wire logic [PW-1:0]     pcLoadVal,
  input  wire logic              pcAdvance,
  output logic [PW-1:0]          fetchAddr,
  output logic [DW-1:0]          cpuRdData,
  output logic                   cpuRdValid,
  output logic                   cpuStall,
  output logic                   dataMemSel,
  output logic [DW-1:0]          dataMemAddr,
  // program memory side
  output psm_pkg::psm_mem_t      memReq,
  input  wire logic [PW-1:0]     memRdData
);
  import psm_pkg::*;

  // ---------------- register file over axi4-lite ----------------
  logic [7:0]  tblPage_ff, nxt_tblPage;
  logic [7:0]  visPage_ff, nxt_visPage;
  logic [7:0]  coreCtl_ff, nxt_coreCtl;
  logic [7:0]  awAddr_ff, nxt_awAddr;
  logic        awHave_ff, nxt_awHave;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0]  wStrb_ff, nxt_wStrb;
  logic        wHave_ff, nxt_wHave;
  logic        bValid_ff, nxt_bValid;
  logic [1:0]  bResp_ff, nxt_bResp;
  logic        rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0]  rResp_ff, nxt_rResp;
  logic        busy_ff;
  logic        awRdy_ff, wRdy_ff, arRdy_ff;

  always_comb begin
    nxt_tblPage = tblPage_ff;
    nxt_visPage = visPage_ff;
    nxt_coreCtl = coreCtl_ff;
    nxt_awAddr  = awAddr_ff;
    nxt_awHave  = awHave_ff;
    nxt_wData   = wData_ff;
    nxt_wStrb   = wStrb_ff;
    nxt_wHave   = wHave_ff;
    nxt_bValid  = bValid_ff;
    nxt_bResp   = bResp_ff;
    nxt_rValid  = rValid_ff;
    nxt_rData   = rData_ff;
    nxt_rResp   = rResp_ff;
    if (s_awvalid && !awHave_ff) begin
      nxt_awAddr = s_awaddr;
      nxt_awHave = 1'b1;
    end
    if (s_wvalid && !wHave_ff) begin
      nxt_wData  = s_wdata;
      nxt_wStrb  = s_wstrb;
      nxt_wHave  = 1'b1;
    end
    if (awHave_ff && wHave_ff && !bValid_ff) begin
      nxt_awHave = 1'b0;
      nxt_wHave  = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp  = AXI_OKAY;
      case (awAddr_ff)
        OFF_TBLPAGE: if (wStrb_ff[0]) nxt_tblPage = wData_ff[7:0];
        OFF_VISPAGE: if (wStrb_ff[0]) nxt_visPage = wData_ff[7:0];
        OFF_CORECTL: if (wStrb_ff[0]) nxt_coreCtl = wData_ff[7:0];
        OFF_STATUS:  nxt_bResp = AXI_OKAY;
        default:     nxt_bResp = AXI_SLVERR;
      endcase
    end
    if (bValid_ff && s_bready) begin
      nxt_bValid = 1'b0;
    end
    if (rValid_ff && s_rready) begin
      nxt_rValid = 1'b0;
    end else if (s_arvalid && !rValid_ff) begin
      nxt_rValid = 1'b1;
      nxt_rResp  = AXI_OKAY;
      case (s_araddr)
        OFF_TBLPAGE: nxt_rData = {24'h000000, tblPage_ff};
        OFF_VISPAGE: nxt_rData = {24'h000000, visPage_ff};
        OFF_CORECTL: nxt_rData = {24'h000000, coreCtl_ff};
        OFF_STATUS:  nxt_rData = {31'h00000000, busy_ff};
        default: begin
          nxt_rData = 32'h00000000;
          nxt_rResp = AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tblPage_ff <= RST_TBLPAGE;
      visPage_ff <= RST_VISPAGE;
      coreCtl_ff <= RST_CORECTL;
      awAddr_ff  <= 8'h00;
      awHave_ff  <= 1'b0;
      wData_ff   <= 32'h00000000;
      wStrb_ff   <= 4'h0;
      wHave_ff   <= 1'b0;
      bValid_ff  <= 1'b0;
      bResp_ff   <= AXI_OKAY;
      rValid_ff  <= 1'b0;
      rData_ff   <= 32'h00000000;
      rResp_ff   <= AXI_OKAY;
      awRdy_ff   <= 1'b1;
      wRdy_ff    <= 1'b1;
      arRdy_ff   <= 1'b1;
    end else begin
      tblPage_ff <= nxt_tblPage;
      visPage_ff <= nxt_visPage;
      coreCtl_ff <= nxt_coreCtl;
      awAddr_ff  <= nxt_awAddr;
      awHave_ff  <= nxt_awHave;
      wData_ff   <= nxt_wData;
      wStrb_ff   <= nxt_wStrb;
      wHave_ff   <= nxt_wHave;
      bValid_ff  <= nxt_bValid;
      bResp_ff   <= nxt_bResp;
      rValid_ff  <= nxt_rValid;
      rData_ff   <= nxt_rData;
      rResp_ff   <= nxt_rResp;
      // readies registered so every port comes from a flop
      awRdy_ff   <= !nxt_awHave;
      wRdy_ff    <= !nxt_wHave;
      arRdy_ff   <= !nxt_rValid;
    end
  end

  assign s_awready = awRdy_ff;
  assign s_wready  = wRdy_ff;
  assign s_bvalid  = bValid_ff;
  assign s_bresp   = bResp_ff;
  assign s_arready = arRdy_ff;
  assign s_rvalid  = rValid_ff;
  assign s_rdata   = rData_ff;
  assign s_rresp   = rResp_ff;

  // ---------------- program counter ----------------
  logic [PW-1:0] pc_ff, nxt_pc;
  always_comb begin
    nxt_pc = pc_ff;
    if (pcLoad) begin
      nxt_pc = pcLoadVal;
    end else if (pcAdvance) begin
      nxt_pc = pc_ff + PC_STEP;
    end
  end

  // ---------------- access sequencer ----------------
  psm_state_t    state_ff, nxt_state;
  psm_op_t       op_ff, nxt_op;
  logic          byteSel_ff, nxt_byteSel;
  logic          byteMode_ff, nxt_byteMode;
  logic          win;
  logic          tableOp;
  psm_mem_t      nxt_mem, mem_ff;
  logic [DW-1:0] nxt_rd, rd_ff;
  logic          nxt_rdV, rdV_ff;
  logic          nxt_dSel, dSel_ff;
  logic [DW-1:0] nxt_dAddr, dAddr_ff;
  logic [7:0]    lo8, hi8;
  logic          stall_ff;

  assign tableOp = cpuReq.op inside {OP_RDLO, OP_RDHI, OP_WRLO, OP_WRHI};
  // table traffic owns the memory port, so the window waits
  assign win = (cpuReq.op == OP_DATA) && cpuReq.effAddr[DW-1]
               && coreCtl_ff[WIN_EN_BIT] && !busy_ff;
  assign lo8 = byteSel_ff ? memRdData[15:8] : memRdData[7:0];
  assign hi8 = memRdData[23:16];

  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_byteSel  = byteSel_ff;
    nxt_byteMode = byteMode_ff;
    nxt_mem      = '0;
    nxt_rd       = rd_ff;
    nxt_rdV      = 1'b0;
    nxt_dSel     = 1'b0;
    nxt_dAddr    = dAddr_ff;
    case (state_ff)
      ST_IDLE: begin
        if (tableOp) begin
          nxt_mem.valid    = 1'b1;
          nxt_mem.addr     = {tblPage_ff, cpuReq.effAddr};
          nxt_mem.cfgSpace = tblPage_ff[CFG_SPACE_BIT];
          nxt_mem.wr       = cpuReq.op inside {OP_WRLO, OP_WRHI};
          if (cpuReq.op == OP_WRLO) begin
            // a byte write takes its byte from the source low byte
            nxt_mem.wrData = cpuReq.byteMode
                           ? {8'h00, cpuReq.wrData[7:0], cpuReq.wrData[7:0]}
                           : {8'h00, cpuReq.wrData};
            nxt_mem.laneEn = cpuReq.byteMode
                           ? (cpuReq.effAddr[0] ? 3'b010 : 3'b001)
                           : 3'b011;
          end else if (cpuReq.op == OP_WRHI) begin
            nxt_mem.wrData = {cpuReq.wrData[7:0], 16'h0000};
            // phantom byte cannot be written
            nxt_mem.laneEn = (cpuReq.byteMode && cpuReq.effAddr[0])
                           ? 3'b000 : 3'b100;
          end
          nxt_op       = cpuReq.op;
          nxt_byteSel  = cpuReq.effAddr[0];
          nxt_byteMode = cpuReq.byteMode;
          nxt_state    = ST_MEM;
        end else if (win) begin
          nxt_mem.valid = 1'b1;
          // bit 23 forced low: user memory only
          nxt_mem.addr  = {1'b0, visPage_ff,
                           cpuReq.effAddr[14:0]};
          nxt_op        = OP_DATA;
          nxt_state     = ST_MEM;
        end else if (cpuReq.op == OP_DATA) begin
          nxt_dSel  = 1'b1;
          nxt_dAddr = cpuReq.effAddr;
        end
      end
      ST_MEM: begin
        nxt_rdV = !(op_ff inside {OP_WRLO, OP_WRHI});
        case (op_ff)
          OP_RDLO: nxt_rd = byteMode_ff ? {8'h00, lo8}
                                        : memRdData[15:0];
          OP_RDHI: nxt_rd = (byteMode_ff && byteSel_ff) ? 16'h0000
                                        : {8'h00, hi8};
          OP_DATA: nxt_rd = memRdData[15:0];
          default: nxt_rd = rd_ff;
        endcase
        // window read holds the core one more cycle
        nxt_state = (op_ff == OP_DATA) ? ST_EXTRA : ST_IDLE;
        if (op_ff == OP_DATA) begin
          nxt_rdV = 1'b0;
        end
      end
      ST_EXTRA: begin
        nxt_rdV   = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_ff       <= '0;
      state_ff    <= ST_IDLE;
      op_ff       <= OP_NONE;
      byteSel_ff  <= 1'b0;
      byteMode_ff <= 1'b0;
      mem_ff      <= '0;
      rd_ff       <= '0;
      rdV_ff      <= 1'b0;
      dSel_ff     <= 1'b0;
      dAddr_ff    <= '0;
      busy_ff     <= 1'b0;
      stall_ff    <= 1'b0;
    end else begin
      pc_ff       <= nxt_pc;
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      byteSel_ff  <= nxt_byteSel;
      byteMode_ff <= nxt_byteMode;
      mem_ff      <= nxt_mem;
      rd_ff       <= nxt_rd;
      rdV_ff      <= nxt_rdV;
      dSel_ff     <= nxt_dSel;
      dAddr_ff    <= nxt_dAddr;
      busy_ff     <= (nxt_state != ST_IDLE)
                     && (nxt_op inside {OP_RDLO, OP_RDHI, OP_WRLO, OP_WRHI});
      stall_ff    <= (nxt_state != ST_IDLE);
    end
  end

  assign fetchAddr   = {1'b0, pc_ff[22:1], 1'b0};
  assign memReq      = mem_ff;
  assign cpuRdData   = rd_ff;
  assign cpuRdValid  = rdV_ff;
  assign cpuStall    = stall_ff;
  assign dataMemSel  = dSel_ff;
  assign dataMemAddr = dAddr_ff;
endmodule // psm_mapper
`default_nettype wire

// *** dv/psm_mapper_properties.sv ***
// psm_mapper_chk: port-level properties of the program space mapper.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module psm_mapper_chk
  import psm_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire psm_pkg::psm_req_t cpuReq,
  input wire logic              cpuStall,
  input wire logic              cpuRdValid,
  input wire logic [DW-1:0]     cpuRdData,
  input wire psm_pkg::psm_mem_t memReq,
  input wire logic              dataMemSel,
  input wire logic [DW-1:0]     dataMemAddr,
  input wire logic [PW-1:0]     fetchAddr,
  input wire logic              pcLoad,
  input wire logic [PW-1:0]     pcLoadVal,
  input wire logic              pcAdvance
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic          tk;
  psm_op_t       op;
  logic [DW-1:0] ea;
  assign op = cpuReq.op;
  assign ea = cpuReq.effAddr;
  assign tk = !cpuStall && op != OP_NONE;
  // answer latency tolerated at 2 or 3 edges; the bench only pins window reads at one cycle past a table read
  chk_tbl_addr: assert property (
    tk && op inside {OP_RDLO, OP_RDHI, OP_WRLO, OP_WRHI} |=>
    memReq.valid && memReq.addr[15:1] == $past(ea[15:1]))
    else $error("table address wrong");
  chk_wr_lanes: assert property (
    tk && op == OP_WRLO && !cpuReq.byteMode |=> memReq.wr &&
    memReq.laneEn == 3'h3 && memReq.wrData[15:0] == $past(cpuReq.wrData))
    else $error("low word write lanes wrong");
  chk_win_route: assert property (
    tk && op == OP_DATA |=> (memReq.valid && !memReq.wr &&
    !memReq.addr[23] && memReq.addr[14:0] == $past(ea[14:0])) ||
    (dataMemSel && dataMemAddr == $past(ea)))
    else $error("data access routed wrong");
  chk_low_half: assert property (
    tk && op == OP_DATA && !ea[15] |=> dataMemSel && !memReq.valid)
    else $error("low half went to program space");
  chk_hi_phantom: assert property (
    tk && op == OP_RDHI && !cpuReq.byteMode |->
    ##[2:3] cpuRdValid && cpuRdData[15:8] == 8'h00)
    else $error("phantom byte not zero");
  chk_hi_sel: assert property (
    tk && op == OP_RDHI && cpuReq.byteMode && ea[0] |->
    ##[2:3] cpuRdValid && cpuRdData[7:0] == 8'h00)
    else $error("phantom byte read not zero");
  chk_pc_step: assert property (
    pcAdvance && !pcLoad |=>
    fetchAddr[22:1] == $past(fetchAddr[22:1]) + 22'h1)
    else $error("pc step wrong");
  chk_pc_load: assert property (
    pcLoad |=> fetchAddr == {1'h0, $past(pcLoadVal[22:1]), 1'h0})
    else $error("fetch address form wrong");
  cov_win: cover property (tk && op == OP_DATA && ea[15]);
  cov_rdhi: cover property (tk && op == OP_RDHI && cpuReq.byteMode);
  cov_wr: cover property (tk && op == OP_WRHI);
endmodule // psm_mapper_chk
bind psm_mapper psm_mapper_chk u_chk (.*);
`default_nettype wire

// *** dv/psm_prog_mem_model.sv ***
// psm_prog_mem_model: program memory array behind the mapper.
// assumes a read is answered in the same cycle that memReq shows it.
`timescale 1ns/1ps
`default_nettype none
module psm_prog_mem_model
  import psm_pkg::*;
(
  input  wire logic              clk,
  input  wire psm_pkg::psm_mem_t memReq,
  output logic [PW-1:0]          memRdData
);
  logic [PW-1:0] a, wd, last;
  assign a  = {memReq.addr[PW-1:1], 1'h0};
  assign wd = {a[15] ? 8'hFF : a[8:1] ^ 8'hC3,
               a[15:0] ^ 16'h5A5A};
  initial last = '0;
  always @(posedge clk) begin
    if (memReq.valid && !memReq.wr) begin
      last <= wd;
    end
  end
  // mapper samples read data while its request stands
  // writes are not stored; idle data is inverted so it never looks fresh
  assign memRdData = (memReq.valid && !memReq.wr) ? wd : ~last;
endmodule // psm_prog_mem_model
`default_nettype wire

// *** dv/psm_mapper_tb.sv ***
// psm_mapper_tb: register and cpu-side access sequences for the mapper.
// assumes the memory model answers reads while the request stands.
`timescale 1ns/1ps
`default_nettype none
module psm_mapper_tb;
  import psm_pkg::*;
  logic          clk = 1'h0, rst = 1'h1;
  logic [7:0]    s_awaddr = '0, s_araddr = '0;
  logic          s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic          s_arvalid = 1'h0, s_rready = 1'h0;
  logic          s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [31:0]   s_wdata = '0, s_rdata, rd;
  logic [3:0]    s_wstrb = 4'hF;
  logic [1:0]    s_bresp, s_rresp, rr;
  psm_req_t      cpuReq = '0;
  logic          pcLoad = 1'h0, pcAdvance = 1'h0;
  logic          cpuRdValid, cpuStall, dataMemSel, seen, dm;
  logic [PW-1:0] pcLoadVal = '0, fetchAddr, memRdData, p;
  logic [DW-1:0] cpuRdData, dataMemAddr, d;
  psm_mem_t      memReq, mq;
  int            n, nt, fail_count = 0, comparisons = 0;

  psm_mapper dut (.*);
  psm_prog_mem_model u_mem (.clk(clk), .memReq(memReq),
                            .memRdData(memRdData));
  always #2.5 clk = ~clk;

  function automatic logic [23:0] pw(input logic [23:0] a);
    return {a[15] ? 8'hFF : a[8:1] ^ 8'hC3, a[15:0] ^ 16'h5A5A};
  endfunction

  task ck(input logic [47:0] g, x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_awaddr  <= a;
    s_awvalid <= 1'h1;
    s_wdata   <= v;
    s_wvalid  <= 1'h1;
    s_bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (s_bvalid !== 1'h1);
    rr = s_bresp;
    s_bready <= 1'h0;
  endtask

  task axr(input logic [7:0] a);
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'h1;
    s_rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'h0;
    end while (s_rvalid !== 1'h1);
    rd = s_rdata;
    rr = s_rresp;
    s_rready <= 1'h0;
  endtask

  // one request, then watch six cycles for every kind of answer
  task cop(input psm_op_t o, input logic b, input logic [15:0] e, w);
    @(posedge clk);
    cpuReq <= '{o, b, e, w};
    @(posedge clk);
    cpuReq.op <= OP_NONE;
    {n, seen, dm, mq, d} = '0;
    for (int i = 0; i < 6; i++) begin
      if (i > 0) @(posedge clk);
      #1;
      if (memReq.valid === 1'h1 && !seen) {seen, mq} = {1'h1, memReq};
      if (dataMemSel === 1'h1) dm = 1'h1;
      if (cpuRdValid === 1'h1) {n, d} = {i, cpuRdData};
    end
  endtask

  task tr(input psm_op_t o, input logic b, input logic [15:0] e, x);
    cop(o, b, e, 16'h0);
    ck(b ? {8'h0, d[7:0]} : d, x);
    ck({mq.cfgSpace, mq.addr}, {1'h0, 8'h12, e});
  endtask

  task win(input logic [7:0] vp, input logic [15:0] e);
    axw(OFF_VISPAGE, {24'h0, vp});
    cop(OP_DATA, 1'h0, e, 16'h0);
    p = pw({1'h0, vp, e[14:1], 1'h0});
    ck(mq.addr, {1'h0, vp, e[14:0]});
    ck(d, p[15:0]);
    ck(n, nt + 1);
  endtask

  task summarize;
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      axr(8'(4 * k));
      ck({rr, rd}, '0);
    end
    axr(8'h10);
    ck({rr, rd}, {AXI_SLVERR, 32'h0});
    axw(OFF_TBLPAGE, 32'h85);
    axr(OFF_TBLPAGE);
    ck({rr, rd}, {AXI_OKAY, 32'h85});
    cop(OP_WRLO, 1'h0, 16'h1234, 16'hBEEF);
    ck({mq.cfgSpace, mq.wr, mq.laneEn, mq.addr, mq.wrData[15:0]},
       {2'h3, 3'h3, 24'h851234, 16'hBEEF});
    cop(OP_WRLO, 1'h1, 16'h1235, 16'h0055);
    ck({mq.laneEn, mq.wrData[15:8]}, {3'h2, 8'h55});
    cop(OP_WRHI, 1'h1, 16'h1234, 16'h00A7);
    ck({mq.laneEn, mq.wrData[23:16]}, {3'h4, 8'hA7});
    axw(OFF_TBLPAGE, 32'h12);
    p = pw(24'h120046);
    tr(OP_RDLO, 1'h0, 16'h0046, p[15:0]);
    nt = n;
    tr(OP_RDLO, 1'h1, 16'h0047, {8'h0, p[15:8]});
    tr(OP_RDLO, 1'h1, 16'h0046, {8'h0, p[7:0]});
    tr(OP_RDHI, 1'h0, 16'h0046, {8'h0, p[23:16]});
    tr(OP_RDHI, 1'h1, 16'h0046, {8'h0, p[23:16]});
    tr(OP_RDHI, 1'h1, 16'h0047, 16'h0);
    cop(OP_DATA, 1'h0, 16'h8ABC, 16'h0);
    ck({dm, seen}, 2'h2);
    axw(OFF_CORECTL, 32'h4);
    win(8'h03, 16'h8ABC);
    win(8'h02, 16'h8ABC);
    win(8'hFF, 16'hFFFE);
    cop(OP_DATA, 1'h0, 16'h0ABC, 16'h0);
    ck({dm, seen}, 2'h2);
    @(posedge clk);
    pcLoad    <= 1'h1;
    pcLoadVal <= 24'hFFFFFF;
    @(posedge clk);
    pcLoad    <= 1'h0;
    pcAdvance <= 1'h1;
    #1 ck(fetchAddr, 24'h7FFFFE);
    repeat (3) @(posedge clk);
    pcAdvance <= 1'h0;
    #1 ck(fetchAddr, 24'h000004);
    summarize();
  end
endmodule // psm_mapper_tb
`default_nettype wire
